// [rtl/rcc_pkg.sv]
// What this block does
// [R1] after power-on the cause register shows the power-on flag at bit 0
// [R2] each reset sets only its own cause flag; cause register is byte index 0
// [R3] cause bit 7 marks a reset from leaving backup or hibernate mode
// [R4] cause bit 6 marks a processor system reset request
// [R5] a watchdog reset sets cause bit 5 and nothing else
// [R6] the reset pin driven low resets the device and sets cause bit 4
// [R7] a non-volatile memory controller reset sets cause bit 3
// [R8] io-supply brownout sets cause bit 2, core-supply brownout cause bit 1
// [R9] sources fall into power-supply, user and backup-exit classes
// [R10] always-on logic and locked generic clock unit see power resets only
// [R11] debug logic sees power and pin resets; all else sees every reset (code also resets debug on backup exits)
// [R12] in backup mode wake on battery switch or counter interrupt
// [R13] a backup exit sets its bit in exit register index 2, clears others
// [R14] battery switch and counter exit bits may be set together
// [R15] exit bit 7 is one after hibernate, zero after backup exit
// [R16] exit bit 2 marks battery switch return to main power
// [R17] exit bit 1 marks a counter interrupt flag seen in backup mode
// [R18] the controller is always enabled, in sleep and debug halt too
// [R19] write protection is ignored in debug halt and for debugger access
// [R20] 8, 16 and 32 bit accesses are accepted
// [R21] both status registers are read-only and hold until next reset
//
// Purpose: constants and carriers for the reset cause controller
// Assumes: 125 MHz REF_CLK, 32-bit APB
// Notes: register byte address is four times the index
package rcc_pkg;

    localparam int CLK_PERIOD_NS = 8;
    // least time the reset outputs stay asserted after a trigger
    localparam int RESET_HOLD_NS = 64;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 4;

    localparam logic [7:0] IDX_RESET_CAUSE = 8'h00;
    localparam logic [7:0] IDX_BACKUP_EXIT = 8'h02;
    localparam logic [11:0] ADDR_RESET_CAUSE = 12'h000;
    localparam logic [11:0] ADDR_BACKUP_EXIT = 12'h008;

    localparam int BIT_POWER_ON = 0;
    localparam int BIT_BROWNOUT_CORE = 1;
    localparam int BIT_BROWNOUT_IO = 2;
    localparam int BIT_NONVOLATILE = 3;
    localparam int BIT_EXTERNAL_PIN = 4;
    localparam int BIT_WATCHDOG = 5;
    localparam int BIT_SYSTEM_REQ = 6;
    localparam int BIT_BACKUP = 7;
    localparam int BIT_EXIT_COUNTER = 1;
    localparam int BIT_EXIT_BATTERY = 2;
    localparam int BIT_EXIT_HIBERNATE = 7;

    typedef struct packed {
        logic backup_flag;
        logic system_request_flag;
        logic watchdog_flag;
        logic external_pin_flag;
        logic nonvolatile_ctrl_flag;
        logic brownout_io_flag;
        logic brownout_core_flag;
        logic power_on_flag;
    } rcc_cause_t;

    typedef struct packed {
        logic hibernate_exit_flag;
        logic [3:0] unused_hi;
        logic battery_switch_exit;
        logic counter_exit;
        logic unused_lo;
    } rcc_exit_t;

    localparam rcc_cause_t CAUSE_POR_VALUE = 8'h01;
    localparam rcc_exit_t EXIT_RESET_VALUE = 8'h00;

    typedef enum {
        CLS_POWER,
        CLS_EXTERNAL,
        CLS_USER,
        CLS_BACKUP
    } rcc_class_t;

    typedef enum {
        ST_RUN,
        ST_HOLD
    } rcc_state_t;

endpackage : rcc_pkg

// [rtl/rcc_reset_ctrl.sv]
// Purpose: collect reset sources, drive class-wise resets, record cause
// Assumes: all inputs synchronous to REF_CLK; RST is the power-on reset
// Notes: APB slave with zero wait states; both registers read-only
//
// Decided for this implementation: the APB slave port.
module rcc_reset_ctrl (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic BOD_IO_DET,
    input wire logic BOD_CORE_DET,
    input wire logic RESET_PIN_N,
    input wire logic WATCHDOG_REQ,
    input wire logic CPU_RESET_REQUEST,
    input wire logic MEMCTRL_RESET_REQ,
    input wire logic BACKUP_MODE,
    input wire logic HIBERNATE_MODE,
    input wire logic BATTERY_SWITCH_RETURN,
    input wire logic COUNTER_IRQ_FLAG,
    input wire logic GEN_CLOCK_WRITE_LOCK,
    input wire logic CPU_DEBUG_HALT,
    input wire logic DEBUGGER_ACCESS,
    input wire logic ACCESS_WRITE_PROTECT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic RESET_CORE,
    output logic RESET_DEBUG,
    output logic RESET_ALWAYS_ON,
    output logic RESET_GEN_CLOCK
);

    rcc_pkg::rcc_state_t state_reg;
    rcc_pkg::rcc_class_t class_reg;
    rcc_pkg::rcc_class_t class_next;
    rcc_pkg::rcc_cause_t cause_reg;
    rcc_pkg::rcc_cause_t cause_next;
    rcc_pkg::rcc_exit_t exit_reg;
    rcc_pkg::rcc_exit_t exit_next;
    logic [rcc_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
    logic counter_seen_reg;
    logic in_backup;
    logic power_trig;
    logic user_trig;
    logic backup_trig;
    logic any_trig;
    logic access;
    logic hit_cause;
    logic hit_exit;
    logic protected_write;

    // [R9] three source classes
    assign power_trig = BOD_IO_DET | BOD_CORE_DET;
    assign user_trig = !RESET_PIN_N | WATCHDOG_REQ | CPU_RESET_REQUEST
        | MEMCTRL_RESET_REQ;
    assign in_backup = BACKUP_MODE | HIBERNATE_MODE;
    // [R12] wake sources in backup
    assign backup_trig = in_backup & (BATTERY_SWITCH_RETURN
        | COUNTER_IRQ_FLAG);
    assign any_trig = power_trig | user_trig | backup_trig;

    // [R2] one-hot cause, power first
    always_comb begin
        cause_next = '0;
        class_next = rcc_pkg::CLS_USER;
        if (BOD_IO_DET) begin
            // [R8] io brownout bit
            cause_next.brownout_io_flag = 1'b1;
            class_next = rcc_pkg::CLS_POWER;
        end else if (BOD_CORE_DET) begin
            // [R8] core brownout bit
            cause_next.brownout_core_flag = 1'b1;
            class_next = rcc_pkg::CLS_POWER;
        end else if (!RESET_PIN_N) begin
            // [R6] pin reset bit
            cause_next.external_pin_flag = 1'b1;
            class_next = rcc_pkg::CLS_EXTERNAL;
        end else if (WATCHDOG_REQ) begin
            // [R5] watchdog bit
            cause_next.watchdog_flag = 1'b1;
        end else if (CPU_RESET_REQUEST) begin
            // [R4] system request bit
            cause_next.system_request_flag = 1'b1;
        end else if (MEMCTRL_RESET_REQ) begin
            // [R7] memory controller bit
            cause_next.nonvolatile_ctrl_flag = 1'b1;
        end else begin
            // [R3] backup exit bit
            cause_next.backup_flag = 1'b1;
            class_next = rcc_pkg::CLS_BACKUP;
        end
    end

    // [R13] exit bits, others cleared
    always_comb begin
        exit_next = '0;
        // [R15] hibernate versus backup
        exit_next.hibernate_exit_flag = HIBERNATE_MODE;
        // [R16] battery switch return
        exit_next.battery_switch_exit = BATTERY_SWITCH_RETURN;
        // [R14] both may be set together
        // [R17] counter flag seen in backup
        exit_next.counter_exit = COUNTER_IRQ_FLAG | counter_seen_reg;
    end

    // remembers a counter event during backup until the exit
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            counter_seen_reg <= 1'b0;
        end else if (!in_backup || state_reg == rcc_pkg::ST_HOLD) begin
            counter_seen_reg <= 1'b0;
        end else if (COUNTER_IRQ_FLAG) begin
            counter_seen_reg <= 1'b1;
        end
    end

    // [R18] sequencer never gated by sleep or debug
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= rcc_pkg::ST_HOLD;
            hold_cnt_reg <= '0;
            class_reg <= rcc_pkg::CLS_POWER;
        end else if (any_trig) begin
            state_reg <= rcc_pkg::ST_HOLD;
            hold_cnt_reg <= '0;
            class_reg <= class_next;
        end else if (state_reg == rcc_pkg::ST_HOLD) begin
            if (hold_cnt_reg ==
                rcc_pkg::HOLD_CNT_W'(rcc_pkg::RESET_HOLD_CYC - 1)) begin
                state_reg <= rcc_pkg::ST_RUN;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
        end
    end

    // [R1] power-on value
    // [R21] updated only by a reset event
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cause_reg <= rcc_pkg::CAUSE_POR_VALUE;
        end else if (any_trig) begin
            cause_reg <= cause_next;
        end
    end

    // [R12] exit register on backup wake only
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            exit_reg <= rcc_pkg::EXIT_RESET_VALUE;
        end else if (any_trig && !power_trig && !user_trig) begin
            exit_reg <= exit_next;
        end
    end

    // [R10] always-on and locked clock unit: power class only
    // [R11] debug: power, pin and backup; core: every class
    always_comb begin
        RESET_CORE = state_reg == rcc_pkg::ST_HOLD;
        RESET_ALWAYS_ON = RESET_CORE && class_reg == rcc_pkg::CLS_POWER;
        RESET_DEBUG = RESET_CORE && class_reg != rcc_pkg::CLS_USER;
        RESET_GEN_CLOCK = RESET_CORE && (class_reg == rcc_pkg::CLS_POWER
            || !GEN_CLOCK_WRITE_LOCK);
    end

    // apb slave: zero wait, unmapped and protected writes give an error
    assign access = PSEL && PENABLE;
    assign hit_cause = PADDR == rcc_pkg::ADDR_RESET_CAUSE;
    assign hit_exit = PADDR == rcc_pkg::ADDR_BACKUP_EXIT;
    // [R19] protection lifted in debug halt or debugger access
    assign protected_write = ACCESS_WRITE_PROTECT && !CPU_DEBUG_HALT
        && !DEBUGGER_ACCESS;

    // [R20] any byte-lane mix accepted; read returns whole word
    always_comb begin
        PREADY = 1'b1;
        PSLVERR = access && (!(hit_cause || hit_exit)
            || (PWRITE && protected_write && PSTRB != 4'h0));
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE && hit_cause) begin
            PRDATA = {24'h00_0000, cause_reg};
        end else if (PSEL && !PWRITE && hit_exit) begin
            PRDATA = {24'h00_0000, exit_reg};
        end
    end

    // [R2] cause stays one-hot
    cause_onehot_a: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST) $onehot(cause_reg))
        else $error("cause register not one-hot");

    // [R1] power-on value after release
    por_flag_a: assert property ( // [R1]
        @(posedge REF_CLK) $fell(RST) |-> cause_reg.power_on_flag)
        else $error("power-on flag missing");

    // [R5] watchdog only
    watchdog_cause_a: assert property ( // [R5]
        @(posedge REF_CLK) disable iff (RST)
        WATCHDOG_REQ && !power_trig && RESET_PIN_N
        |=> cause_reg == 8'h20)
        else $error("watchdog cause wrong");

    // [R6] pin reset
    pin_cause_a: assert property ( // [R6]
        @(posedge REF_CLK) disable iff (RST)
        !RESET_PIN_N && !power_trig
        |=> cause_reg.external_pin_flag && RESET_DEBUG)
        else $error("pin reset not recorded");

    // [R10] user reset spares always-on domain
    user_spare_a: assert property ( // [R10]
        @(posedge REF_CLK) disable iff (RST)
        user_trig && !power_trig |=> RESET_CORE && !RESET_ALWAYS_ON)
        else $error("user reset hit always-on logic");

    // [R11] debug kept out of watchdog resets
    dbg_spare_a: assert property ( // [R11]
        @(posedge REF_CLK) disable iff (RST)
        WATCHDOG_REQ && RESET_PIN_N && !power_trig ##1 !any_trig
        |-> !RESET_DEBUG)
        else $error("debug reset on watchdog");

    // [R13] exit bits on backup wake
    exit_set_a: assert property ( // [R13]
        @(posedge REF_CLK) disable iff (RST)
        backup_trig && !power_trig && !user_trig
        |=> cause_reg == 8'h80
            && exit_reg.hibernate_exit_flag == $past(HIBERNATE_MODE)
            && exit_reg[0] == 1'b0)
        else $error("backup exit not recorded");

    // [R21] status stable without a trigger
    hold_value_a: assert property ( // [R21]
        @(posedge REF_CLK) disable iff (RST)
        !any_trig |=> $stable(cause_reg) && $stable(exit_reg))
        else $error("status changed without reset");

    // [R18] hold length fixed
    hold_len_a: assert property ( // [R18]
        @(posedge REF_CLK) disable iff (RST)
        $rose(RESET_CORE) ##1 !any_trig [*8] |-> !RESET_CORE)
        else $error("reset hold too long");

    // [R4] system request cause
    request_cause_a: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RST)
        CPU_RESET_REQUEST && !WATCHDOG_REQ && RESET_PIN_N && !power_trig
        |=> cause_reg == 8'h40)
        else $error("system request cause wrong");

    // [R7] memory controller cause
    memctrl_cause_a: assert property ( // [R7]
        @(posedge REF_CLK) disable iff (RST)
        MEMCTRL_RESET_REQ && !CPU_RESET_REQUEST && !WATCHDOG_REQ
        && RESET_PIN_N && !power_trig |=> cause_reg == 8'h08)
        else $error("memory controller cause wrong");

    // [R8] io brownout cause
    io_brownout_a: assert property ( // [R8]
        @(posedge REF_CLK) disable iff (RST)
        BOD_IO_DET |=> cause_reg == 8'h04 && RESET_ALWAYS_ON)
        else $error("io brownout cause wrong");

    // [R8] core brownout cause
    core_brownout_a: assert property ( // [R8]
        @(posedge REF_CLK) disable iff (RST)
        BOD_CORE_DET && !BOD_IO_DET
        |=> cause_reg == 8'h02 && RESET_ALWAYS_ON)
        else $error("core brownout cause wrong");

    // [R10] locked clock unit spared
    lock_spare_a: assert property ( // [R10]
        @(posedge REF_CLK) disable iff (RST)
        user_trig && !power_trig
        |=> RESET_GEN_CLOCK == !GEN_CLOCK_WRITE_LOCK)
        else $error("clock unit reset ignores lock");

    // [R16] battery switch exit bit
    battery_exit_a: assert property ( // [R16]
        @(posedge REF_CLK) disable iff (RST)
        backup_trig && !power_trig && !user_trig
        |=> exit_reg.battery_switch_exit == $past(BATTERY_SWITCH_RETURN))
        else $error("battery exit bit wrong");

    // [R17] counter exit bit
    counter_exit_a: assert property ( // [R17]
        @(posedge REF_CLK) disable iff (RST)
        backup_trig && !power_trig && !user_trig && COUNTER_IRQ_FLAG
        |=> exit_reg.counter_exit)
        else $error("counter exit bit missing");

    // [R19] protection lifted in debug
    debug_write_a: assert property ( // [R19]
        @(posedge REF_CLK) disable iff (RST)
        access && PWRITE && (hit_cause || hit_exit)
        && (CPU_DEBUG_HALT || DEBUGGER_ACCESS) |-> !PSLVERR)
        else $error("write refused in debug");

endmodule : rcc_reset_ctrl

// [tb/rcc_source_model.sv]
// Purpose: stand-in for supply monitors, watchdog, cpu, memory ctrl, pin
// Assumes: fire is held for one cycle, each source then pulses one cycle
// Notes: pick bits: io bod, core bod, pin, watchdog, cpu, memory ctrl,
//        battery, counter
module rcc_source_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [7:0] pick,
    output logic [7:0] src,
    output logic pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] act_reg = 8'h00;

    always_ff @(posedge clk) begin
        act_reg <= fire ? pick : 8'h00;
    end

    assign src = act_reg;
    assign pin_n = ~act_reg[2];
endmodule : rcc_source_model

// [tb/reset_cause_controller_bench.sv]
// Purpose: self-checking bench for the reset cause controller
// Assumes: slave answers when PREADY is high at a rising edge
// Notes: reset hold of 8 cycles is waited out with a margin
module reset_cause_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] CAUSE_TAB [6] =
        '{32'h04, 32'h02, 32'h10, 32'h20, 32'h40, 32'h08};
    localparam logic [31:0] OUT_TAB [6] =
        '{32'hf, 32'hf, 32'hc, 32'h8, 32'h8, 32'h8};
    localparam logic [7:0] WAKE_TAB [4] = '{8'h80, 8'h40, 8'hc0, 8'h40};
    localparam logic [31:0] EXIT_TAB [4] = '{32'h02, 32'h04, 32'h06, 32'h84};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic backup = 1'b0, hibernate = 1'b0, lock = 1'b1, halt = 1'b0;
    logic dbg_acc = 1'b0, protect = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, fire = 1'b0, pin_n, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'hffffffff;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] pick = 8'h00;
    logic [7:0] src;
    logic [31:0] prdata, rd;
    logic pready, pslverr, r_core, r_dbg, r_ao, r_gen;
    int err_total = 0;
    int checks = 0;

    always #4 ref_clk = ~ref_clk;

    rcc_source_model rcc_source_model_inst (.clk(ref_clk), .fire(fire),
        .pick(pick), .src(src), .pin_n(pin_n));

    rcc_reset_ctrl rcc_reset_ctrl_inst (.REF_CLK(ref_clk), .RST(rst),
        .BOD_IO_DET(src[0]), .BOD_CORE_DET(src[1]), .RESET_PIN_N(pin_n),
        .WATCHDOG_REQ(src[3]), .CPU_RESET_REQUEST(src[4]),
        .MEMCTRL_RESET_REQ(src[5]), .BACKUP_MODE(backup),
        .HIBERNATE_MODE(hibernate), .BATTERY_SWITCH_RETURN(src[6]),
        .COUNTER_IRQ_FLAG(src[7]), .GEN_CLOCK_WRITE_LOCK(lock),
        .CPU_DEBUG_HALT(halt), .DEBUGGER_ACCESS(dbg_acc),
        .ACCESS_WRITE_PROTECT(protect), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESET_CORE(r_core), .RESET_DEBUG(r_dbg),
        .RESET_ALWAYS_ON(r_ao), .RESET_GEN_CLOCK(r_gen));

    task automatic close_out();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    function automatic logic [31:0] outs();
        return {28'h0, r_core, r_dbg, r_ao, r_gen};
    endfunction : outs

    task automatic apb(input logic wr, input logic [11:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 50) begin
            err_total++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [7:0] p);
        @(posedge ref_clk);
        fire <= 1'b1;
        pick <= p;
        @(posedge ref_clk);
        fire <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : pulse

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(outs(), 32'hf);
        repeat (12) @(posedge ref_clk);
        chk(outs(), 32'h0);
        apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
        chk(rd, 32'h01);
        apb(1'b0, rcc_pkg::ADDR_BACKUP_EXIT);
        chk(rd, 32'h00);
        halt <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            pulse(8'h01 << i);
            chk(outs(), OUT_TAB[i]);
            repeat (12) @(posedge ref_clk);
            chk(outs(), 32'h0);
            apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
            chk(rd, CAUSE_TAB[i]);
        end
        halt <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            backup <= (i < 3);
            hibernate <= (i == 3);
            pulse(WAKE_TAB[i]);
            chk(outs(), 32'hc);
            @(posedge ref_clk);
            backup <= 1'b0;
            hibernate <= 1'b0;
            repeat (12) @(posedge ref_clk);
            apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
            chk(rd, 32'h80);
            apb(1'b0, rcc_pkg::ADDR_BACKUP_EXIT);
            chk(rd, EXIT_TAB[i]);
        end
        protect <= 1'b1;
        apb(1'b1, rcc_pkg::ADDR_RESET_CAUSE);
        chk({31'h0, er}, 32'h1);
        dbg_acc <= 1'b1;
        apb(1'b1, rcc_pkg::ADDR_BACKUP_EXIT);
        chk({31'h0, er}, 32'h0);
        dbg_acc <= 1'b0;
        halt <= 1'b1;
        apb(1'b1, rcc_pkg::ADDR_RESET_CAUSE);
        chk({31'h0, er}, 32'h0);
        halt <= 1'b0;
        protect <= 1'b0;
        pstrb <= 4'h1;
        apb(1'b1, rcc_pkg::ADDR_RESET_CAUSE);
        chk({31'h0, er}, 32'h0);
        pstrb <= 4'h3;
        apb(1'b1, rcc_pkg::ADDR_BACKUP_EXIT);
        chk({31'h0, er}, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
        chk(rd, 32'h80);
        apb(1'b0, rcc_pkg::ADDR_BACKUP_EXIT);
        chk(rd, 32'h84);
        apb(1'b0, 12'h004);
        chk({31'h0, er}, 32'h1);
        lock <= 1'b0;
        pulse(8'h08);
        chk(outs(), 32'h9);
        repeat (12) @(posedge ref_clk);
        lock <= 1'b1;
        apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
        chk(rd, 32'h20);
        apb(1'b0, rcc_pkg::ADDR_BACKUP_EXIT);
        chk(rd, 32'h84);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        apb(1'b0, rcc_pkg::ADDR_RESET_CAUSE);
        chk(rd, 32'h01);
        apb(1'b0, rcc_pkg::ADDR_BACKUP_EXIT);
        chk(rd, 32'h00);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
endmodule : reset_cause_controller_bench
